// File: inc/ricd_cfg.svh
// constants for the remote input command decoder
// assumes inclusion by bare name from inc/
`ifndef RICD_CFG_SVH
`define RICD_CFG_SVH
`define RICD_WORD_W      16
`define RICD_TABLE_W     5
`define RICD_RESP_NORMAL 16'h0000
`define RICD_RESP_ERROR  16'h0001
`define RICD_TABLE_MAX   5'h1F
`define RICD_SPEED_MAX   16'h7FFF
`define RICD_REFRESH_DIV 32'h10
`define RICD_REG_CTRL    8'h00
`define RICD_REG_STATUS  8'h04
`define RICD_REG_IRQ_ST  8'h08
`define RICD_REG_IRQ_MSK 8'h0C
`define RICD_REG_POS_LO  8'h10
`define RICD_REG_POS_HI  8'h14
`define RICD_REG_SPEED   8'h18
`define RICD_REG_TABLE   8'h1C
`define RICD_REG_RESP    8'h20
`define RICD_IRQ_POS     0
`define RICD_IRQ_SPD     1
`define RICD_IRQ_ERR     2
`endif

// File: inc/ricd_pkg.sv
// types for the remote input command decoder
// assumes ricd_cfg.svh is on the include path
`include "ricd_cfg.svh"
package ricd_pkg;
  typedef logic [`RICD_WORD_W-1:0]  ricd_word_t;
  typedef logic [`RICD_TABLE_W-1:0] ricd_table_t;
  typedef enum logic [1:0] {
    RICD_TL_SPLIT    = 2'h0,
    RICD_TL_INTERNAL = 2'h1
  } ricd_tlim_t;
endpackage

// File: inc/ricd_if.sv
// link between fieldbus master end and servo command decoder end
// assumes both ends share clk; one sample per refresh strobe
`timescale 1ns/10ps
interface ricd_if;
  logic                 refresh;
  logic                 pos_demand;
  logic                 spd_demand;
  logic                 torque_limit_select_bit;
  logic                 proportional_control_bit;
  logic                 gain_switch_bit;
  logic                 command_source_select_bit;
  logic                 abs_incr_select_bit;
  ricd_pkg::ricd_table_t table_select;
  ricd_pkg::ricd_word_t  cmd_word_4;
  ricd_pkg::ricd_word_t  cmd_word_5;
  ricd_pkg::ricd_word_t  cmd_word_6;
  ricd_pkg::ricd_word_t  response_code_word;
  logic                 pos_ack;
  logic                 spd_ack;
  logic                 movement_complete_status;
  modport master (
    output refresh, pos_demand, spd_demand, torque_limit_select_bit,
           proportional_control_bit, gain_switch_bit, command_source_select_bit,
           abs_incr_select_bit, table_select, cmd_word_4, cmd_word_5, cmd_word_6,
    input  response_code_word, pos_ack, spd_ack, movement_complete_status
  );
  modport device (
    input  refresh, pos_demand, spd_demand, torque_limit_select_bit,
           proportional_control_bit, gain_switch_bit, command_source_select_bit,
           abs_incr_select_bit, table_select, cmd_word_4, cmd_word_5, cmd_word_6,
    output response_code_word, pos_ack, spd_ack, movement_complete_status
  );
endinterface

// File: core/ricd_device.sv
// servo side: decodes cyclic remote bits and words into command actions
// assumes master updates link signals and pulses refresh once per link cycle
// Functional notes
// - position demand rise latches words 4,5, answers
// - speed demand rise latches word 6, answers
// - torque select picks split or internal limit
// - proportional bit drops integral term
// - master sets proportional when shaft locked
// - master adds torque select for long lock
// - gain switch bit selects alternate gain set
// - master disables auto tuning for gain switch
// - source bit off uses table select bits
// - source bit on uses command words
// - configuration selects register sourcing beforehand
// - abs/incr bit only valid register+absolute mode
`timescale 1ns/10ps
`include "ricd_cfg.svh"
module ricd_device #(
  parameter int WORD_W = `RICD_WORD_W
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  ricd_if.device             lnk,
  input  wire logic          abs_cmd_mode,
  input  wire logic          move_done,
  output logic               tlim_internal,
  output logic               speed_p_only,
  output logic               alt_gain_sel,
  output logic               pos_incremental,
  output logic               cmd_from_regs,
  output logic [31:0]        pos_cmd,
  output logic [WORD_W-1:0]  speed_cmd,
  output logic [4:0]         table_cmd,
  output logic               pos_strobe,
  output logic               spd_strobe
);
  // a level that rises and falls between two samples is never seen: the
  // master has to hold each demand for at least one full link cycle
  typedef struct packed {
    // previous link samples of the demands
    logic              pos_d;
    logic              spd_d;

    // level selections handed to the servo loops
    logic              tlim;
    logic              ponly;
    logic              gain;
    logic              src;
    logic              incr;

    // handshake back to the master and take strobes
    logic              pos_ack;
    logic              spd_ack;
    logic              pos_stb;
    logic              spd_stb;
    logic              mdone;

    // latched command data and the answer code
    logic [31:0]       pos;
    logic [WORD_W-1:0] spd;
    logic [4:0]        tbl;
    logic [WORD_W-1:0] resp;
  } ricd_dev_st_t;

  ricd_dev_st_t st_ff;
  ricd_dev_st_t nxt_st;

  // table number must lie within the table; speed must be non-negative
  function automatic logic tbl_bad(input logic [WORD_W-1:0] w);
    tbl_bad = (w > WORD_W'(`RICD_TABLE_MAX));
  endfunction

  // a demand counts only on a low-to-high step between two link samples
  function automatic logic demand_rose(
    input logic now_smp,
    input logic prev_smp
  );
    demand_rose = now_smp & ~prev_smp;
  endfunction

  // increments only mean something with register sourcing in absolute mode
  function automatic logic incr_in_force(
    input logic from_regs,
    input logic abs_mode,
    input logic incr_sel
  );
    incr_in_force = from_regs & abs_mode & incr_sel;
  endfunction

  // every position value or table number is accepted as latched
  function automatic logic [WORD_W-1:0] pos_answer();
    pos_answer = WORD_W'(`RICD_RESP_NORMAL);
  endfunction

  // a negative speed word or an out-of-table number is refused; every
  // table number fits today, but a smaller table only needs a new maximum
  function automatic logic [WORD_W-1:0] spd_answer(
    input logic              from_regs,
    input logic [WORD_W-1:0] speed_word,
    input logic [4:0]        tbl_num
  );
    logic bad;
    if (from_regs) begin
      bad = (speed_word > WORD_W'(`RICD_SPEED_MAX));
    end else begin
      bad = tbl_bad(WORD_W'(tbl_num));
    end
    if (bad) begin
      spd_answer = WORD_W'(`RICD_RESP_ERROR);
    end else begin
      spd_answer = WORD_W'(`RICD_RESP_NORMAL);
    end
  endfunction

  logic pos_rise;
  logic spd_rise;
  logic src_now;

  // rise detection sits outside the state update so the priority between
  // the two demands is visible in one place
  assign src_now  = lnk.command_source_select_bit;
  assign pos_rise = lnk.refresh & demand_rose(lnk.pos_demand, st_ff.pos_d);
  // position wins a same-sample rise; speed is only taken on its own next rise
  assign spd_rise = lnk.refresh & demand_rose(lnk.spd_demand, st_ff.spd_d) & ~pos_rise;

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.pos_stb = 1'b0;
    nxt_st.spd_stb = 1'b0;
    nxt_st.mdone   = move_done;

    // levels are taken once per link cycle and held in between
    if (lnk.refresh) begin
      nxt_st.pos_d = lnk.pos_demand;
      nxt_st.spd_d = lnk.spd_demand;
      nxt_st.tlim  = lnk.torque_limit_select_bit;
      nxt_st.ponly = lnk.proportional_control_bit;
      nxt_st.gain  = lnk.gain_switch_bit;
      nxt_st.src   = src_now;
      nxt_st.incr  = incr_in_force(src_now, abs_cmd_mode, lnk.abs_incr_select_bit);
    end

    // an acknowledge falls at the first sample that sees its demand low
    if (lnk.refresh && !lnk.pos_demand) begin
      nxt_st.pos_ack = 1'b0;
    end
    if (lnk.refresh && !lnk.spd_demand) begin
      nxt_st.spd_ack = 1'b0;
    end

    // answer and acknowledge change together, so the master never sees
    // an acknowledge beside a stale answer
    if (pos_rise) begin
      nxt_st.pos_stb = 1'b1;
      nxt_st.pos_ack = 1'b1;
      nxt_st.resp    = pos_answer();
      if (src_now) begin
        nxt_st.pos = {lnk.cmd_word_5, lnk.cmd_word_4};
      end else begin
        nxt_st.tbl = lnk.table_select;
      end
    end

    // speed demand: same shape, the answer depends on the source
    if (spd_rise) begin
      nxt_st.spd_stb = 1'b1;
      nxt_st.spd_ack = 1'b1;
      nxt_st.resp    = spd_answer(src_now, lnk.cmd_word_6, lnk.table_select);
      if (src_now) begin
        nxt_st.spd = lnk.cmd_word_6;
      end else begin
        nxt_st.tbl = lnk.table_select;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // servo loop selections, held between link samples
  assign tlim_internal   = st_ff.tlim;
  assign speed_p_only    = st_ff.ponly;
  assign alt_gain_sel    = st_ff.gain;
  assign pos_incremental = st_ff.incr;
  assign cmd_from_regs   = st_ff.src;

  // latched command data and one-cycle take strobes
  assign pos_cmd         = st_ff.pos;
  assign speed_cmd       = st_ff.spd;
  assign table_cmd       = st_ff.tbl;
  assign pos_strobe      = st_ff.pos_stb;
  assign spd_strobe      = st_ff.spd_stb;

  // link answers back to the master
  assign lnk.response_code_word       = st_ff.resp;
  assign lnk.pos_ack                  = st_ff.pos_ack;
  assign lnk.spd_ack                  = st_ff.spd_ack;
  // movement completion goes back through one register like every link output
  assign lnk.movement_complete_status = st_ff.mdone;
endmodule // ricd_device

// File: core/ricd_master.sv
// fieldbus master end: software drives link bits through avalon registers
// assumes one clock shared with the device end
`timescale 1ns/10ps
`include "ricd_cfg.svh"
module ricd_master #(
  parameter int REFRESH_DIV = `RICD_REFRESH_DIV
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  ricd_if.master           lnk,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);
  typedef struct packed {
    logic [6:0]  ctrl;
    logic [4:0]  tbl;
    logic [15:0] w4;
    logic [15:0] w5;
    logic [15:0] w6;
    logic [2:0]  ist;
    logic [2:0]  imsk;
    logic        pack_d;
    logic        sack_d;
    logic        md_d;
    logic [7:0]  div;
    logic        ref_p;
    logic        done;
    logic [31:0] rdata;
  } ricd_mst_st_t;

  ricd_mst_st_t st_ff;
  ricd_mst_st_t nxt_st;
  logic         acc;
  logic         md_fall;
  logic         fin;

  assign acc     = (avs_read | avs_write) & ~st_ff.done;
  // completing cycle: waitrequest is low, the request still stands
  assign fin     = (avs_read | avs_write) & st_ff.done;
  assign md_fall = st_ff.md_d & ~lnk.movement_complete_status;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.done   = acc;
    nxt_st.ref_p  = (st_ff.div == 8'(REFRESH_DIV - 1));
    nxt_st.div    = nxt_st.ref_p ? 8'h00 : st_ff.div + 8'h01;
    nxt_st.pack_d = lnk.pos_ack;
    nxt_st.sack_d = lnk.spd_ack;
    nxt_st.md_d   = lnk.movement_complete_status;
    // writes land only at the edge that completes the transfer
    if (fin && avs_write) begin
      unique case (avs_address)
        `RICD_REG_CTRL:    nxt_st.ctrl = avs_writedata[6:0];
        `RICD_REG_TABLE:   nxt_st.tbl  = avs_writedata[4:0];
        `RICD_REG_POS_LO:  nxt_st.w4   = avs_writedata[15:0];
        `RICD_REG_POS_HI:  nxt_st.w5   = avs_writedata[15:0];
        `RICD_REG_SPEED:   nxt_st.w6   = avs_writedata[15:0];
        `RICD_REG_IRQ_MSK: nxt_st.imsk = avs_writedata[2:0];
        `RICD_REG_IRQ_ST:  nxt_st.ist  = st_ff.ist & ~avs_writedata[2:0];
        default: ;
      endcase
    end
    // set wins over write-one clear
    if (lnk.pos_ack && !st_ff.pack_d)
      nxt_st.ist[`RICD_IRQ_POS] = 1'b1;
    if (lnk.spd_ack && !st_ff.sack_d)
      nxt_st.ist[`RICD_IRQ_SPD] = 1'b1;
    if (md_fall)
      nxt_st.ist[`RICD_IRQ_ERR] = 1'b1;
    nxt_st.rdata = 32'h0000_0000;
    if (acc && avs_read) begin
      unique case (avs_address)
        `RICD_REG_CTRL:    nxt_st.rdata = {25'h0, st_ff.ctrl};
        `RICD_REG_STATUS:  nxt_st.rdata = {29'h0, lnk.movement_complete_status,
                                           lnk.spd_ack, lnk.pos_ack};
        `RICD_REG_IRQ_ST:  nxt_st.rdata = {29'h0, st_ff.ist};
        `RICD_REG_IRQ_MSK: nxt_st.rdata = {29'h0, st_ff.imsk};
        `RICD_REG_POS_LO:  nxt_st.rdata = {16'h0, st_ff.w4};
        `RICD_REG_POS_HI:  nxt_st.rdata = {16'h0, st_ff.w5};
        `RICD_REG_SPEED:   nxt_st.rdata = {16'h0, st_ff.w6};
        `RICD_REG_TABLE:   nxt_st.rdata = {27'h0, st_ff.tbl};
        `RICD_REG_RESP:    nxt_st.rdata = {16'h0, lnk.response_code_word};
        default:           nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign avs_waitrequest = acc;
  assign avs_readdata    = st_ff.rdata;
  assign irq             = |(st_ff.ist & st_ff.imsk);

  assign lnk.refresh                   = st_ff.ref_p;
  assign lnk.pos_demand                = st_ff.ctrl[0];
  assign lnk.spd_demand                = st_ff.ctrl[1];
  // software should set these while shaft locked after move completion drops
  assign lnk.torque_limit_select_bit   = st_ff.ctrl[2];
  assign lnk.proportional_control_bit  = st_ff.ctrl[3];
  assign lnk.gain_switch_bit           = st_ff.ctrl[4];
  assign lnk.command_source_select_bit = st_ff.ctrl[5];
  assign lnk.abs_incr_select_bit       = st_ff.ctrl[6];
  assign lnk.table_select              = st_ff.tbl;
  assign lnk.cmd_word_4                = st_ff.w4;
  assign lnk.cmd_word_5                = st_ff.w5;
  assign lnk.cmd_word_6                = st_ff.w6;
endmodule // ricd_master

// File: verif/ricd_link_checker.sv
// link-side assertions for the remote input command decoder
// assumes the signals of one ricd_if, sampled on clk, reset by nrst
`timescale 1ns/10ps
`include "ricd_cfg.svh"
module ricd_link_checker (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 refresh,
  input wire logic                 pos_demand,
  input wire logic                 spd_demand,
  input wire logic                 command_source_select_bit,
  input wire ricd_pkg::ricd_word_t cmd_word_6,
  input wire ricd_pkg::ricd_word_t response_code_word,
  input wire logic                 pos_ack,
  input wire logic                 spd_ack
);
  logic pd_ff;
  logic sd_ff;
  logic pos_rise;
  logic spd_rise;
  // position wins when both demands rise in one sample
  assign pos_rise = refresh && pos_demand && !pd_ff;
  assign spd_rise = refresh && spd_demand && !sd_ff && !pos_rise;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pd_ff <= 1'b0;
      sd_ff <= 1'b0;
    end else if (refresh) begin
      pd_ff <= pos_demand;
      sd_ff <= spd_demand;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_pos_ack_set: assert property (pos_rise |=> pos_ack)
    else $error("position ack missing");
  a_pos_resp_ok: assert property (pos_rise |=> response_code_word == `RICD_RESP_NORMAL)
    else $error("position response wrong");
  a_spd_ack_set: assert property (spd_rise |=> spd_ack)
    else $error("speed ack missing");
  a_spd_resp_code: assert property (spd_rise |=> response_code_word ==
    ($past(command_source_select_bit && (cmd_word_6 > `RICD_SPEED_MAX)) ?
     `RICD_RESP_ERROR : `RICD_RESP_NORMAL))
    else $error("speed response wrong");
  a_ack_quiet: assert property (!refresh |=> $stable(pos_ack) && $stable(spd_ack))
    else $error("ack moved outside refresh");
  a_resp_quiet: assert property (!refresh |=> $stable(response_code_word))
    else $error("response moved outside refresh");
  a_pos_ack_drop: assert property (refresh && !pos_demand |=> !pos_ack)
    else $error("position ack not dropped");
  a_spd_ack_drop: assert property (refresh && !spd_demand |=> !spd_ack)
    else $error("speed ack not dropped");
  a_spd_ack_keep: assert property (refresh && spd_demand && sd_ff |=>
    spd_ack == $past(spd_ack))
    else $error("speed ack changed on held demand");
endmodule // ricd_link_checker

// File: verif/test_remote_input_command_decoder.sv
// self-checking bench: avalon software drives master end into device end
// assumes REFRESH_DIV of 16; waits on waitrequest only up to a bound
`timescale 1ns/10ps
`include "ricd_cfg.svh"
module test_remote_input_command_decoder;
  logic        clk, nrst, avs_read, avs_write, avs_waitrequest, irq;
  logic        abs_cmd_mode, move_done, pos_strobe, spd_strobe;
  logic        tlim_internal, speed_p_only, alt_gain_sel, pos_incremental, cmd_from_regs;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, pos_cmd, rd;
  logic [15:0] speed_cmd, w4, w5, w6;
  logic [4:0]  table_cmd, tsel;
  logic [6:0]  ctl;
  int          miscompares, cmp_count;
  ricd_if lnk();
  ricd_master i_ricd_master (.clk(clk), .nrst(nrst), .lnk(lnk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
  ricd_device i_ricd_device (.clk(clk), .nrst(nrst), .lnk(lnk), .abs_cmd_mode(abs_cmd_mode),
    .move_done(move_done), .tlim_internal(tlim_internal), .speed_p_only(speed_p_only),
    .alt_gain_sel(alt_gain_sel), .pos_incremental(pos_incremental),
    .cmd_from_regs(cmd_from_regs), .pos_cmd(pos_cmd), .speed_cmd(speed_cmd),
    .table_cmd(table_cmd), .pos_strobe(pos_strobe), .spd_strobe(spd_strobe));
  ricd_link_checker i_ricd_link_checker (.clk(clk), .nrst(nrst), .refresh(lnk.refresh),
    .pos_demand(lnk.pos_demand), .spd_demand(lnk.spd_demand),
    .command_source_select_bit(lnk.command_source_select_bit), .cmd_word_6(lnk.cmd_word_6),
    .response_code_word(lnk.response_code_word), .pos_ack(lnk.pos_ack), .spd_ack(lnk.spd_ack));
  always #5 clk = ~clk;
  task give_verdict;
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function logic [15:0] spd_resp(input logic [15:0] w, input logic src);
    return (src && w > `RICD_SPEED_MAX) ? `RICD_RESP_ERROR : `RICD_RESP_NORMAL;
  endfunction
  // request held until waitrequest is sampled low at a rising edge
  task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      miscompares++;
      give_verdict;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // drop the demand long enough for a refresh to see it low, then raise it
  task go(input int b);
    int n;
    ctl[b] = 1'b0;
    av(1'b1, `RICD_REG_CTRL, {25'h0, ctl});
    repeat (40) @(posedge clk);
    ctl[b] = 1'b1;
    av(1'b1, `RICD_REG_CTRL, {25'h0, ctl});
    n = 0;
    while ((b == 1 ? spd_strobe : pos_strobe) !== 1'b1 && n < 64) begin
      @(negedge clk);
      n++;
    end
    if (n >= 64) begin
      miscompares++;
      give_verdict;
    end
  endtask
  initial begin
    {clk, nrst, avs_read, avs_write, abs_cmd_mode, move_done} = 6'h0;
    {avs_address, avs_writedata, ctl} = 47'h0;
    miscompares = 0;
    cmp_count = 0;
    void'($urandom(13));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    av(1'b0, `RICD_REG_CTRL, 32'h0);
    chk("ctrl_reset", rd, 32'h0);
    av(1'b0, 8'hFC, 32'h0);
    chk("unmapped_read", rd, 32'h0);
    av(1'b1, `RICD_REG_IRQ_MSK, 32'h7);
    for (int i = 0; i < 10; i++) begin
      w4 = 16'($urandom());
      w5 = 16'($urandom());
      w6 = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 : 16'($urandom());
      tsel = 5'($urandom());
      abs_cmd_mode <= 1'($urandom());
      // 0,1: register speed at and past the limit; 2: long lock; 3: table mode
      ctl[6:2] = (i == 2) ? 5'h1F : (i < 2) ? 5'h08 :
                 (i == 3) ? 5'h00 : 5'($urandom());
      av(1'b1, `RICD_REG_POS_LO, {16'h0, w4});
      av(1'b1, `RICD_REG_POS_HI, {16'h0, w5});
      av(1'b1, `RICD_REG_SPEED, {16'h0, w6});
      av(1'b1, `RICD_REG_TABLE, {27'h0, tsel});
      go(0);
      if (ctl[5]) chk("pos_cmd", pos_cmd, {w5, w4});
      else chk("table_cmd", {27'h0, table_cmd}, {27'h0, tsel});
      chk("pos_resp", {16'h0, lnk.response_code_word}, 32'h0);
      chk("pos_ack", {31'h0, lnk.pos_ack}, 32'h1);
      go(1);
      if (ctl[5]) chk("speed_cmd", {16'h0, speed_cmd}, {16'h0, w6});
      else chk("table_cmd_spd", {27'h0, table_cmd}, {27'h0, tsel});
      chk("spd_resp", {16'h0, lnk.response_code_word}, {16'h0, spd_resp(w6, ctl[5])});
      chk("spd_ack", {31'h0, lnk.spd_ack}, 32'h1);
      chk("tlim", {31'h0, tlim_internal}, {31'h0, ctl[2]});
      chk("p_only", {31'h0, speed_p_only}, {31'h0, ctl[3]});
      chk("alt_gain", {31'h0, alt_gain_sel}, {31'h0, ctl[4]});
      chk("from_regs", {31'h0, cmd_from_regs}, {31'h0, ctl[5]});
      chk("incr", {31'h0, pos_incremental}, {31'h0, ctl[5] & abs_cmd_mode & ctl[6]});
      av(1'b0, `RICD_REG_STATUS, 32'h0);
      chk("status", rd, 32'h3);
      av(1'b0, `RICD_REG_RESP, 32'h0);
      chk("resp_reg", rd, {16'h0, spd_resp(w6, ctl[5])});
      av(1'b0, `RICD_REG_IRQ_ST, 32'h0);
      chk("irq_st", rd, 32'h3);
      chk("irq_on", {31'h0, irq}, 32'h1);
      av(1'b1, `RICD_REG_IRQ_ST, 32'h3);
      av(1'b0, `RICD_REG_IRQ_ST, 32'h0);
      chk("irq_clr", rd, 32'h0);
      chk("irq_off", {31'h0, irq}, 32'h0);
    end
    av(1'b1, `RICD_REG_IRQ_MSK, 32'h0);
    move_done <= 1'b1;
    go(0);
    av(1'b0, `RICD_REG_STATUS, 32'h0);
    chk("status_md", rd, 32'h7);
    move_done <= 1'b0;
    repeat (4) @(posedge clk);
    av(1'b0, `RICD_REG_IRQ_ST, 32'h0);
    chk("irq_masked_st", rd, 32'h5);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    give_verdict;
  end
endmodule // test_remote_input_command_decoder
